// *** dv/bfrm_rx_model.sv ***
// port b receiver model: drains the output buffer, with stalls
`timescale 1ns/1ns
module bfrm_rx_model (
  // clock
  input wire logic clk_in,
  // buffer head from the design
  input wire logic [bfrm_pkg::DW-1:0] data_in,
  input wire logic valid_in,
  // stall request from the bench
  input wire logic stall_in,
  // ready back to the design
  output logic ready_out = 1'b0
);
  logic [bfrm_pkg::DW-1:0] got [$];
  logic [1:0] ph_q = 2'h0;
  ////////////////////////////////////////////////////////////////////////////////
  // ready drops one cycle in four, moved only off the sampling edge
  always @(negedge clk_in) begin
    ph_q <= ph_q + 2'h1;
    ready_out <= !stall_in && (ph_q != 2'h3);
  end
  // keep each word popped by the handshake
  always @(posedge clk_in) begin
    if (valid_in && ready_out) begin
      got.push_back(data_in);
    end
  end
endmodule

// *** dv/bfrm_top_tb.sv ***
// self-checking bench for the two fifos, flags, offsets and mailboxes
`timescale 1ns/1ns
module bfrm_top_tb;
  localparam int D = 16;
  localparam logic [2:0] RD = 3'h7;
  localparam logic [2:0] WR = 3'h6;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  bfrm_pkg::bfrm_ctl_s a_ctl = '0, b_ctl = '0;
  logic [2:0] a_sel = 3'h0;
  logic b_sel = 1'b0, a_oe_n = 1'b1, b_oe_n = 1'b1, stall = 1'b0, b_rdy;
  logic [35:0] a_d = '0, b_d = '0, a_q, b_q;
  logic a_oe, b_v, b_oe, nm1_n, nm2_n;
  bfrm_pkg::bfrm_flags_s f1, f2;
  int err_total = 0, n_checks = 0;
  // 50 MHz clock
  always #10 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////////////
  // design with a 16-deep fifo, and the port b receiver
  bfrm_top #(.AW(4)) bfrm_top_i (.clk_in(clk_in), .rst_in(rst_in), .a_ctl_in(a_ctl),
    .a_sel_in(a_sel), .a_data_in(a_d), .a_oe_n_in(a_oe_n), .a_data_out(a_q),
    .a_data_oe_out(a_oe), .b_ctl_in(b_ctl), .b_sel_in(b_sel), .b_data_in(b_d),
    .b_oe_n_in(b_oe_n), .b_ready_in(b_rdy), .b_data_out(b_q), .b_valid_out(b_v),
    .b_data_oe_out(b_oe), .f1_flags_out(f1), .f2_flags_out(f2),
    .new_mail1_n_out(nm1_n), .new_mail2_n_out(nm2_n));
  bfrm_rx_model bfrm_rx_model_i (.clk_in(clk_in), .data_in(b_q), .valid_in(b_v),
    .stall_in(stall), .ready_out(b_rdy));
  ////////////////////////////////////////////////////////////////////////////////
  // compare and report
  task automatic chk_d(string nm, logic [35:0] e, logic [35:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_f(string nm, bfrm_pkg::bfrm_flags_s e, bfrm_pkg::bfrm_flags_s g);
    chk_d(nm, 36'(e), 36'(g));
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // expected flags for a fill level and an almost-full offset
  function automatic bfrm_pkg::bfrm_flags_s ef(int n, int af);
    ef.full_n = n != D;
    ef.half_n = n < D / 2;
    ef.empty_n = n != 0;
    ef.afull_n = D - n > af;
    ef.aempty_n = n > bfrm_pkg::OFS_RST;
  endfunction
  // one access held over one rising edge, then idle cycles
  task automatic op(bit pb, logic [2:0] c, logic [2:0] sel, logic [35:0] d, int idle);
    @(negedge clk_in);
    if (pb) begin
      b_ctl = bfrm_pkg::bfrm_ctl_s'(c);
      b_sel = sel[0];
      b_d = d;
    end else begin
      a_ctl = bfrm_pkg::bfrm_ctl_s'(c);
      a_sel = sel;
      a_d = d;
    end
    @(negedge clk_in);
    a_ctl = '0;
    b_ctl = '0;
    repeat (idle + 1) @(negedge clk_in);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    repeat (6) @(negedge clk_in);
    rst_in = 1'b0;
    @(negedge clk_in);
    chk_f("f1 rst", ef(0, 8), f1);
    chk_f("f2 rst", ef(0, 8), f2);
    chk_d("mail rst", 36'h3, {nm1_n, nm2_n});
    chk_d("b oe rst", 36'h0, b_oe);
    op(0, RD, 3'h5, 0, 0);
    chk_d("ofs all", {9'h8, 9'h8, 9'h8, 9'h8}, a_q);
    op(0, WR, 3'h2, 36'h5, 0);
    op(0, RD, 3'h2, 0, 0);
    chk_d("ofs af1", 36'h5, a_q);
    op(0, 3'h2, 3'h7, 36'h1, 0);
    op(0, 3'h4, 3'h7, 36'h1, 0);
    chk_f("f1 no gate", ef(0, 5), f1);
    // fill past full, then drain through the port b buffer
    for (int i = 1; i <= D + 1; i++) begin
      op(0, WR, 3'h7, 36'h100 + i, 0);
      chk_f("f1 fill", ef(i > D ? D : i, 5), f1);
    end
    for (int i = D - 1; i >= 0; i--) begin
      op(1, RD, 3'h1, 0, 3);
      chk_f("f1 drain", ef(i, 5), f1);
    end
    op(1, RD, 3'h1, 0, 3);
    chk_d("rx count", 36'(D), 36'(bfrm_rx_model_i.got.size()));
    for (int i = 0; i < D; i++) begin
      chk_d("rx word", 36'h101 + i, bfrm_rx_model_i.got[i]);
    end
    bfrm_rx_model_i.got.delete();
    // receiver stalls: two words fit, the third read is refused
    for (int i = 0; i < 3; i++) begin
      op(0, WR, 3'h7, 36'h200 + i, 0);
    end
    stall = 1'b1;
    repeat (3) op(1, RD, 3'h1, 0, 0);
    chk_f("f1 stall", ef(1, 5), f1);
    chk_d("b head", 36'h200, b_q);
    stall = 1'b0;
    repeat (4) @(negedge clk_in);
    op(1, RD, 3'h1, 0, 6);
    chk_d("rx stall", 36'h3, 36'(bfrm_rx_model_i.got.size()));
    chk_d("rx last", 36'h202, bfrm_rx_model_i.got[2]);
    bfrm_rx_model_i.got.delete();
    // fifo 2 read by port a with drivers off, then on
    op(1, WR, 3'h1, 36'h301, 0);
    op(1, WR, 3'h1, 36'h302, 0);
    chk_f("f2 two", ef(2, 8), f2);
    op(0, RD, 3'h7, 0, 1);
    chk_d("a oe off", 36'h0, a_oe);
    chk_d("a word", 36'h301, a_q);
    a_oe_n = 1'b0;
    op(0, RD, 3'h7, 0, 1);
    chk_d("a oe on", 36'h1, a_oe);
    chk_d("a word", 36'h302, a_q);
    op(0, RD, 3'h7, 0, 1);
    chk_d("a empty rd", 36'h302, a_q);
    chk_f("f2 empty", ef(0, 8), f2);
    // mailboxes in both directions
    op(0, WR, 3'h6, 36'h4a1, 0);
    chk_d("mail1 set", 36'h0, nm1_n);
    op(1, RD, 3'h0, 0, 4);
    chk_d("mail1 clr", 36'h1, nm1_n);
    chk_d("mail1 word", 36'h4a1, bfrm_rx_model_i.got[0]);
    op(1, WR, 3'h0, 36'h4b2, 0);
    chk_d("mail2 set", 36'h0, nm2_n);
    op(0, RD, 3'h6, 0, 1);
    chk_d("mail2 word", 36'h4b2, a_q);
    chk_d("mail2 clr", 36'h1, nm2_n);
    chk_f("f1 mail", ef(0, 5), f1);
    chk_f("f2 mail", ef(0, 8), f2);
    // combined offset word: four distinct fields written and read back
    op(0, WR, 3'h5, {9'h9, 9'h7, 9'h6, 9'h5}, 0);
    op(0, RD, 3'h5, 0, 0);
    chk_d("ofs comb", {9'h9, 9'h7, 9'h6, 9'h5}, a_q);
    // port b drivers follow their enable
    b_oe_n = 1'b0;
    repeat (2) @(negedge clk_in);
    chk_d("b oe on", 36'h1, b_oe);
    results();
  end
  // watchdog against a hang
  initial begin
    #100000;
    err_total++;
    results();
  end
endmodule

// *** src/bfrm_pkg.sv ***
// constants and carrier types for the bidirectional fifo with flags and mailboxes
// Notes on behaviour
// - a full fifo ignores writes; the first read frees a slot and clears full
// - port a reads fifo 2, port b reads fifo 1
// - read starts on clock edge with gate, ask, read direction and fifo select; port b reads also need room in the output buffer
// - read word is presented on the port data bus after the starting edge
// - output enable only switches drivers; read completes and word is held
// - an empty fifo refuses reads; the first write clears empty
// - six dedicated active-low flags: full, half-full, empty for each fifo
// - full asserts after the filling write, deasserts after a read from full
// - half-full updates after any access that changes half-full status
// - empty asserts after the emptying read, deasserts after a write into empty
// - almost-full and almost-empty per fifo, offsets reset to eight, reprogrammable
// - almost-full asserts on reaching its offset, deasserts after dropping below
// - almost-empty asserts on reaching its offset, deasserts after rising past
// - offsets read and written only through port a, combined or individual words
// - combined offset word carries nine-bit magnitudes only
// - two mailboxes; each port reads its own and writes the other's
// - mailbox access on clock edge with mailbox select, gate and ask high; port b mailbox reads also need output buffer room
// - direction picks mailbox read or write; output enable gates the driven word
// - port a select 111 fifo, 110 mailbox, 101 and 000 to 011 offsets, 100 unused; port b 1 fifo, 0 mailbox
// - each mailbox has a new-mail flag that never blocks accesses
// - reset clears pointers and sets all fifo and mailbox flags to empty
package bfrm_pkg;
  localparam int DW = 36;
  localparam int AW = 9;
  localparam int OFS_RST = 8;
  localparam int OFS_COMB_W = 9;
  // port a resource selects
  localparam logic [2:0] SEL_FIFO = 3'h7;
  localparam logic [2:0] SEL_MBOX = 3'h6;
  localparam logic [2:0] SEL_OFS_ALL = 3'h5;
  localparam logic [2:0] SEL_CTRL = 3'h4;
  localparam logic [2:0] SEL_AE1 = 3'h3;
  localparam logic [2:0] SEL_AF1 = 3'h2;
  localparam logic [2:0] SEL_AE2 = 3'h1;
  localparam logic [2:0] SEL_AF2 = 3'h0;
  // port b resource selects
  localparam logic B_SEL_FIFO = 1'h1;
  localparam logic B_SEL_MBOX = 1'h0;
  // output buffer on port b
  localparam int BUF_DEPTH = 2;
  // status flags, all active low
  typedef struct packed {
    logic full_n;
    logic half_n;
    logic empty_n;
    logic afull_n;
    logic aempty_n;
  } bfrm_flags_s;
  localparam bfrm_flags_s FLAGS_RST = '{full_n: 1'h1, half_n: 1'h1, empty_n: 1'h0,
                                        afull_n: 1'h1, aempty_n: 1'h0};
  // per-port access controls
  typedef struct packed {
    logic gate;
    logic ask;
    logic rd;
  } bfrm_ctl_s;
endpackage

// *** src/bfrm_top.sv ***
// two opposite fifos with flags, offsets, mailboxes and a port b output buffer
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// one fifo with pointers, count, dedicated and programmable flags
module bfrm_fifo #(
  parameter int AW = bfrm_pkg::AW,
  parameter int DW = bfrm_pkg::DW
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // access
  input wire logic wr_in,
  input wire logic [DW-1:0] wdata_in,
  input wire logic rd_in,
  // offset programming
  input wire logic af_we_in,
  input wire logic ae_we_in,
  input wire logic [AW-1:0] af_ofs_in,
  input wire logic [AW-1:0] ae_ofs_in,
  // results
  output logic [DW-1:0] rdata_out,
  output logic rvalid_out,
  output bfrm_pkg::bfrm_flags_s flags_out,
  output logic [AW-1:0] af_ofs_out,
  output logic [AW-1:0] ae_ofs_out
);
  localparam logic [AW:0] DEPTH = (AW+1)'(1 << AW);
  localparam logic [AW:0] HALF = DEPTH >> 1;
  localparam logic [AW-1:0] OFS_RST = AW'(bfrm_pkg::OFS_RST);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [DW-1:0] rdata;
    logic rvalid;
    logic [AW-1:0] af;
    logic [AW-1:0] ae;
    bfrm_pkg::bfrm_flags_s fl;
  } bfrm_fst_s;

  bfrm_fst_s q, d;
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic wr_ok;
  logic rd_ok;

  // lockouts at the boundaries
  assign wr_ok = wr_in && (q.cnt != DEPTH);
  assign rd_ok = rd_in && (q.cnt != '0);

  // next state: pointers, count, read word and flags
  always_comb begin
    d = q;
    d.rvalid = rd_ok;
    if (wr_ok) begin
      d.wp = q.wp + 1'b1;
    end
    if (rd_ok) begin
      d.rp = q.rp + 1'b1;
      d.rdata = mem[q.rp];
    end
    if (wr_ok && !rd_ok) begin
      d.cnt = q.cnt + 1'b1;
    end else if (rd_ok && !wr_ok) begin
      d.cnt = q.cnt - 1'b1;
    end
    if (af_we_in) begin
      d.af = af_ofs_in;
    end
    if (ae_we_in) begin
      d.ae = ae_ofs_in;
    end
    d.fl.full_n = !(d.cnt == DEPTH);
    d.fl.half_n = !(d.cnt >= HALF);
    d.fl.empty_n = !(d.cnt == '0);
    d.fl.afull_n = !((DEPTH - d.cnt) <= {1'b0, d.af});
    d.fl.aempty_n = !(d.cnt <= {1'b0, d.ae});
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= '{wp: '0, rp: '0, cnt: '0, rdata: '0, rvalid: 1'h0, af: OFS_RST, ae: OFS_RST,
             fl: bfrm_pkg::FLAGS_RST};
    end else begin
      q <= d;
    end
  end

  // storage array, written only when a write is accepted
  always_ff @(posedge clk_in) begin
    if (wr_ok) begin
      mem[q.wp] <= wdata_in;
    end
  end

  assign rdata_out = q.rdata;
  assign rvalid_out = q.rvalid;
  assign flags_out = q.fl;
  assign af_ofs_out = q.af;
  assign ae_ofs_out = q.ae;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_fill;
    wr_in && !rd_in && q.cnt == DEPTH - 1'b1;
  endsequence
  sequence s_drain;
    rd_in && !wr_in && q.cnt == (AW+1)'(1);
  endsequence

  property p_full_lock;
    wr_in && !rd_in && q.cnt == DEPTH |=> $stable(q.wp) && q.cnt == DEPTH;
  endproperty
  a_full_lock: assert property (p_full_lock) else $error("write taken while full");

  property p_full_flag;
    s_fill |=> !q.fl.full_n ##1 (q.fl.full_n || !$past(rd_in));
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full flag timing");

  property p_empty_lock;
    rd_in && q.cnt == '0 |=> !q.rvalid && $stable(q.rp);
  endproperty
  a_empty_lock: assert property (p_empty_lock) else $error("read taken while empty");

  property p_empty_flag;
    s_drain |=> !q.fl.empty_n && !q.fl.aempty_n;
  endproperty
  a_empty_flag: assert property (p_empty_flag) else $error("empty flag timing");

  property p_empty_clear;
    wr_in && q.cnt == '0 |=> q.fl.empty_n;
  endproperty
  a_empty_clear: assert property (p_empty_clear) else $error("empty flag stuck");

  property p_half;
    q.fl.half_n == (q.cnt < HALF);
  endproperty
  a_half: assert property (p_half) else $error("half flag wrong");

  property p_afull;
    !q.fl.afull_n == ((DEPTH - q.cnt) <= {1'b0, q.af});
  endproperty
  a_afull: assert property (p_afull) else $error("almost full flag wrong");

  property p_aempty;
    wr_in && !rd_in && q.cnt == {1'b0, q.ae} && !ae_we_in |=> q.fl.aempty_n;
  endproperty
  a_aempty: assert property (p_aempty) else $error("almost empty flag stuck");
endmodule

////////////////////////////////////////////////////////////////////////////////
// top: port decode, mailboxes, port a output register, port b buffer
module bfrm_top #(
  parameter int AW = bfrm_pkg::AW,
  parameter int DW = bfrm_pkg::DW
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // port a controls and data
  input wire bfrm_pkg::bfrm_ctl_s a_ctl_in,
  input wire logic [2:0] a_sel_in,
  input wire logic [DW-1:0] a_data_in,
  input wire logic a_oe_n_in,
  output logic [DW-1:0] a_data_out,
  output logic a_data_oe_out,
  // port b controls and data
  input wire bfrm_pkg::bfrm_ctl_s b_ctl_in,
  input wire logic b_sel_in,
  input wire logic [DW-1:0] b_data_in,
  input wire logic b_oe_n_in,
  input wire logic b_ready_in,
  output logic [DW-1:0] b_data_out,
  output logic b_valid_out,
  output logic b_data_oe_out,
  // status flags
  output bfrm_pkg::bfrm_flags_s f1_flags_out,
  output bfrm_pkg::bfrm_flags_s f2_flags_out,
  output logic new_mail1_n_out,
  output logic new_mail2_n_out
);
  localparam int OW = bfrm_pkg::OFS_COMB_W;
  localparam logic [1:0] BUF_FULL = 2'(bfrm_pkg::BUF_DEPTH);

  typedef struct packed {
    logic [DW-1:0] a_data;
    logic a_oe;
    logic b_oe;
    logic [DW-1:0] mb1;
    logic [DW-1:0] mb2;
    logic nm1;
    logic nm2;
    logic mb1_rd;
    logic [1:0][DW-1:0] bufw;
    logic [1:0] bcnt;
    logic bval;
  } bfrm_tst_s;

  bfrm_tst_s q, d;
  logic a_go, b_go, b_room, b_pop;
  logic a_fifo_wr, a_fifo_rd, a_mb_wr, a_mb_rd, a_ofs_wr, a_ofs_rd;
  logic b_fifo_wr, b_fifo_rd, b_mb_wr, b_mb_rd;
  logic af1_we, ae1_we, af2_we, ae2_we;
  logic [AW-1:0] ofs_val, af1, ae1, af2, ae2;
  logic [DW-1:0] f1_rdata, f2_rdata, ofs_word;
  logic f1_rv, f2_rv;

  // port decode: gate and ask both needed
  assign a_go = a_ctl_in.gate && a_ctl_in.ask;
  assign b_go = b_ctl_in.gate && b_ctl_in.ask;
  assign a_fifo_wr = a_go && !a_ctl_in.rd && a_sel_in == bfrm_pkg::SEL_FIFO;
  assign a_fifo_rd = a_go && a_ctl_in.rd && a_sel_in == bfrm_pkg::SEL_FIFO;
  assign a_mb_wr = a_go && !a_ctl_in.rd && a_sel_in == bfrm_pkg::SEL_MBOX;
  assign a_mb_rd = a_go && a_ctl_in.rd && a_sel_in == bfrm_pkg::SEL_MBOX;
  assign a_ofs_wr = a_go && !a_ctl_in.rd && !a_sel_in[2];
  assign a_ofs_rd = a_go && a_ctl_in.rd && (!a_sel_in[2] || a_sel_in == bfrm_pkg::SEL_OFS_ALL);
  // port b reads are refused while the output buffer has no room
  assign b_room = (q.bcnt + 2'(f1_rv) + 2'(q.mb1_rd)) < BUF_FULL;
  assign b_pop = b_ready_in && q.bcnt != '0;
  assign b_fifo_wr = b_go && !b_ctl_in.rd && b_sel_in == bfrm_pkg::B_SEL_FIFO;
  assign b_fifo_rd = b_go && b_ctl_in.rd && b_sel_in == bfrm_pkg::B_SEL_FIFO && b_room;
  assign b_mb_wr = b_go && !b_ctl_in.rd && b_sel_in == bfrm_pkg::B_SEL_MBOX;
  assign b_mb_rd = b_go && b_ctl_in.rd && b_sel_in == bfrm_pkg::B_SEL_MBOX && b_room;

  // offset writes: combined word carries nine-bit fields, single words full width
  always_comb begin
    af1_we = 1'b0;
    ae1_we = 1'b0;
    af2_we = 1'b0;
    ae2_we = 1'b0;
    ofs_val = a_data_in[AW-1:0];
    if (a_ofs_wr) begin
      unique case (a_sel_in)
        bfrm_pkg::SEL_AE1: ae1_we = 1'b1;
        bfrm_pkg::SEL_AF1: af1_we = 1'b1;
        bfrm_pkg::SEL_AE2: ae2_we = 1'b1;
        bfrm_pkg::SEL_AF2: af2_we = 1'b1;
        default: ;
      endcase
    end
  end

  // combined word written as four nine-bit offsets
  logic comb_we;
  assign comb_we = a_go && !a_ctl_in.rd && a_sel_in == bfrm_pkg::SEL_OFS_ALL;

  bfrm_fifo #(.AW(AW), .DW(DW)) u_fifo1 (
    .clk_in(clk_in), .rst_in(rst_in),
    .wr_in(a_fifo_wr), .wdata_in(a_data_in), .rd_in(b_fifo_rd),
    .af_we_in(af1_we || comb_we), .ae_we_in(ae1_we || comb_we),
    .af_ofs_in(comb_we ? AW'(a_data_in[OW +: OW]) : ofs_val),
    .ae_ofs_in(comb_we ? AW'(a_data_in[0 +: OW]) : ofs_val),
    .rdata_out(f1_rdata), .rvalid_out(f1_rv), .flags_out(f1_flags_out),
    .af_ofs_out(af1), .ae_ofs_out(ae1)
  );

  bfrm_fifo #(.AW(AW), .DW(DW)) u_fifo2 (
    .clk_in(clk_in), .rst_in(rst_in),
    .wr_in(b_fifo_wr), .wdata_in(b_data_in), .rd_in(a_fifo_rd),
    .af_we_in(af2_we || comb_we), .ae_we_in(ae2_we || comb_we),
    .af_ofs_in(comb_we ? AW'(a_data_in[3*OW +: OW]) : ofs_val),
    .ae_ofs_in(comb_we ? AW'(a_data_in[2*OW +: OW]) : ofs_val),
    .rdata_out(f2_rdata), .rvalid_out(f2_rv), .flags_out(f2_flags_out),
    .af_ofs_out(af2), .ae_ofs_out(ae2)
  );

  // offset readback word for port a
  always_comb begin
    ofs_word = '0;
    unique case (a_sel_in)
      bfrm_pkg::SEL_AE1: ofs_word[AW-1:0] = ae1;
      bfrm_pkg::SEL_AF1: ofs_word[AW-1:0] = af1;
      bfrm_pkg::SEL_AE2: ofs_word[AW-1:0] = ae2;
      bfrm_pkg::SEL_AF2: ofs_word[AW-1:0] = af2;
      default: ofs_word = {OW'(af2), OW'(ae2), OW'(af1), OW'(ae1)};
    endcase
  end

  // next state: mailboxes, new-mail flags, port a register, port b buffer
  always_comb begin
    d = q;
    d.a_oe = !a_oe_n_in;
    d.b_oe = !b_oe_n_in;
    d.mb1_rd = b_mb_rd;
    if (a_mb_wr) begin
      d.mb1 = a_data_in;
    end
    if (b_mb_wr) begin
      d.mb2 = b_data_in;
    end
    d.nm1 = (q.nm1 && !b_mb_rd) || a_mb_wr;
    d.nm2 = (q.nm2 && !a_mb_rd) || b_mb_wr;
    if (f2_rv) begin
      d.a_data = f2_rdata;
    end else if (a_mb_rd) begin
      d.a_data = q.mb2;
    end else if (a_ofs_rd) begin
      d.a_data = ofs_word;
    end
    if (b_pop) begin
      d.bufw[0] = q.bufw[1];
      d.bcnt = q.bcnt - 1'b1;
    end
    if (f1_rv || q.mb1_rd) begin
      d.bufw[d.bcnt[0]] = f1_rv ? f1_rdata : q.mb1;
      d.bcnt = d.bcnt + 1'b1;
    end
    // registered head-valid so the output comes straight from a flop
    d.bval = d.bcnt != '0;
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign a_data_out = q.a_data;
  assign a_data_oe_out = q.a_oe;
  assign b_data_out = q.bufw[0];
  assign b_valid_out = q.bval;
  assign b_data_oe_out = q.b_oe;
  assign new_mail1_n_out = !q.nm1;
  assign new_mail2_n_out = !q.nm2;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_mail_set;
    a_mb_wr |=> !new_mail1_n_out && a_data_out == $past(a_data_out) || !new_mail1_n_out;
  endproperty
  a_mail_set: assert property (p_mail_set) else $error("new mail flag not set");

  property p_mail_word;
    a_mb_wr ##1 (b_mb_rd && !a_mb_wr) |=> q.mb1_rd ##1 b_valid_out;
  endproperty
  a_mail_word: assert property (p_mail_word) else $error("mailbox word not delivered");

  property p_a_read;
    a_fifo_rd && f2_flags_out.empty_n |=> f2_rv ##1 a_data_out == $past(f2_rdata);
  endproperty
  a_a_read: assert property (p_a_read) else $error("port a read word missing");

  property p_buf_bound;
    q.bcnt <= BUF_FULL;
  endproperty
  a_buf_bound: assert property (p_buf_bound) else $error("port b buffer overflow");

  property p_oe_only;
    a_oe_n_in |=> !a_data_oe_out;
  endproperty
  a_oe_only: assert property (p_oe_only) else $error("port a drivers on while disabled");

  property p_no_ask;
    !a_ctl_in.ask && !b_ctl_in.ask |=> $stable(q.mb1) && $stable(q.mb2);
  endproperty
  a_no_ask: assert property (p_no_ask) else $error("access without ask");
endmodule
